// ===== verilog/phy_bmc_pkg.sv
package phy_bmc_pkg;
	// Clock and soft reset timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned SOFT_RST_NS = 1000;
	localparam int unsigned SOFT_RST_CYCLES = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Bus and data widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned MII_W = 4;
	// Register byte offsets
	localparam logic [11:0] BMC_OFFS = 12'h000;
	localparam logic [11:0] STAT_OFFS = 12'h004;
	// Control register field positions
	localparam int unsigned SRST_BIT = 15;
	localparam int unsigned LOOP_BIT = 14;
	localparam int unsigned SPEED_BIT = 13;
	localparam int unsigned ANEN_BIT = 12;
	localparam int unsigned PWDN_BIT = 11;
	localparam int unsigned ISO_BIT = 10;
	localparam int unsigned ANRS_BIT = 9;
	localparam int unsigned DUPLEX_BIT = 8;
	localparam int unsigned COLT_BIT = 7;
	// Control register reset values
	localparam logic LOOP_RST = 1'b0;
	localparam logic SPEED_RST = 1'b1;
	localparam logic ANEN_RST = 1'b1;
	localparam logic PWDN_RST = 1'b0;
	localparam logic ISO_RST = 1'b0;
	localparam logic ANRS_RST = 1'b0;
	localparam logic DUPLEX_RST = 1'b1;
	localparam logic COLT_RST = 1'b0;
	// Status register field positions
	localparam int unsigned ST_SPEED_BIT = 0;
	localparam int unsigned ST_DUPLEX_BIT = 1;
	localparam int unsigned ST_PWDN_BIT = 2;
	localparam int unsigned ST_ISO_BIT = 3;
	localparam int unsigned ST_SRST_BIT = 4;
	localparam int unsigned ST_PIN_PD_BIT = 5;
	// Strap settle wait after hardware reset
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	// Soft reset sequencer
	typedef enum logic [1:0] {
		RS_RUN,
		RS_SOFT_RST,
		RS_RELATCH
	} rst_state_t;
endpackage

// ===== verilog/sync_2ff.sv
`timescale 1ns/1ps
// Two stage synchroniser for a level from a pin
module sync_2ff #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_ff;
	logic sync_ff;

	// First stage feeds only the second stage
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule // sync_2ff

// ===== verilog/phy_basic_mode_control.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module phy_basic_mode_control #(
	parameter int unsigned RST_CYCLES = phy_bmc_pkg::SOFT_RST_CYCLES,
	parameter int unsigned MII_W = phy_bmc_pkg::MII_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [phy_bmc_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Pins
	input wire logic i_shared_irq_powerdown_pin_n,
	input wire logic i_strap_duplex,
	// Auto-negotiation engine
	input wire logic i_an_started,
	input wire logic i_an_speed_100,
	input wire logic i_an_full_duplex,
	output logic o_an_restart,
	output logic o_an_enable,
	// Core controls
	output logic o_soft_rst,
	output logic o_power_down,
	output logic o_speed_100,
	output logic o_full_duplex,
	output logic o_col_test,
	// MAC side MII
	input wire logic [MII_W-1:0] i_mii_txd,
	input wire logic i_mii_tx_en,
	output logic [MII_W-1:0] o_mii_rxd,
	output logic o_mii_rx_dv,
	output logic o_mii_rx_oe_n,
	// Line side of the core
	input wire logic [MII_W-1:0] i_line_rxd,
	input wire logic i_line_rx_dv,
	output logic [MII_W-1:0] o_line_txd,
	output logic o_line_tx_en
);
	import phy_bmc_pkg::*;

	// Refuse settings the counter or datapath cannot serve
	generate
		if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_bad_rst
			$error("RST_CYCLES must be between 1 and 65535");
		end
		if (MII_W < 1) begin : g_bad_mii
			$error("MII_W must be at least 1");
		end
	endgenerate

	localparam logic [15:0] RST_LOAD = 16'(RST_CYCLES - 1);

	rst_state_t state_ff;
	rst_state_t nxt_state;
	logic [15:0] rst_cnt_ff;
	logic [1:0] strap_wait_ff;

	logic loop_ff;
	logic speed_ff;
	logic an_en_ff;
	logic pwdn_ff;
	logic iso_ff;
	logic an_rs_ff;
	logic duplex_ff;
	logic col_test_ff;

	logic pready_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic an_restart_ff;
	logic soft_rst_ff;
	logic power_down_ff;
	logic speed_100_ff;
	logic full_duplex_ff;
	logic [MII_W-1:0] mii_rxd_ff;
	logic mii_rx_dv_ff;
	logic mii_rx_oe_n_ff;
	logic [MII_W-1:0] line_txd_ff;
	logic line_tx_en_ff;

	logic pin_sync;
	logic strap_sync;
	logic pin_pd_req;
	logic pd_eff;
	logic busy;
	logic setup;
	logic access;
	logic hit_bmc;
	logic hit_stat;
	logic wr_bmc;
	logic start_srst;
	logic start_anrs;
	logic mii_on;
	logic [15:0] bmc_rd;
	logic [15:0] stat_rd;

	// Both pins cross from outside before any logic looks at them
	sync_2ff #(
		.RST_VAL(1'b1)
	) u_pin_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async(i_shared_irq_powerdown_pin_n),
		.o_sync(pin_sync)
	);

	sync_2ff #(
		.RST_VAL(DUPLEX_RST)
	) u_strap_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async(i_strap_duplex),
		.o_sync(strap_sync)
	);

	// Bus decode; transfers complete on the first access cycle
	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable & pready_ff;
	assign hit_bmc = (i_paddr == BMC_OFFS);
	assign hit_stat = (i_paddr == STAT_OFFS);
	assign busy = (state_ff != RS_RUN);
	// Writes during soft reset are dropped; the register is being rebuilt
	assign wr_bmc = access & i_pwrite & hit_bmc & ~busy;
	assign start_srst = wr_bmc & i_pwdata[SRST_BIT];
	// Restart only counts when negotiation stays enabled by this write
	assign start_anrs = wr_bmc & ~i_pwdata[SRST_BIT] &
		i_pwdata[ANRS_BIT] & i_pwdata[ANEN_BIT];

	// Power-down request from the pin, and the combined control
	assign pin_pd_req = ~pin_sync;
	assign pd_eff = pwdn_ff | pin_pd_req;
	// MII carries traffic only when running, powered and not isolated
	assign mii_on = ~busy & ~pd_eff & ~iso_ff;

	// Readback views
	always_comb begin
		bmc_rd = 16'h0000;
		bmc_rd[SRST_BIT] = busy;
		bmc_rd[LOOP_BIT] = loop_ff;
		bmc_rd[SPEED_BIT] = speed_ff;
		bmc_rd[ANEN_BIT] = an_en_ff;
		bmc_rd[PWDN_BIT] = pwdn_ff;
		bmc_rd[ISO_BIT] = iso_ff;
		bmc_rd[ANRS_BIT] = an_rs_ff;
		bmc_rd[DUPLEX_BIT] = duplex_ff;
		bmc_rd[COLT_BIT] = col_test_ff;
	end

	always_comb begin
		stat_rd = 16'h0000;
		stat_rd[ST_SPEED_BIT] = speed_100_ff;
		stat_rd[ST_DUPLEX_BIT] = full_duplex_ff;
		stat_rd[ST_PWDN_BIT] = pd_eff;
		stat_rd[ST_ISO_BIT] = iso_ff;
		stat_rd[ST_SRST_BIT] = busy;
		stat_rd[ST_PIN_PD_BIT] = pin_pd_req;
	end

	// APB answer is prepared in the setup cycle, so no wait states
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			pready_ff <= 1'b1;
			pslverr_ff <= ~(hit_bmc | hit_stat);
			if (i_pwrite | ~(hit_bmc | hit_stat)) begin
				prdata_ff <= 32'h0000_0000;
			end else if (hit_bmc) begin
				prdata_ff <= {16'h0000, bmc_rd};
			end else begin
				prdata_ff <= {16'h0000, stat_rd};
			end
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// Soft reset sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RS_RUN: begin
				if (start_srst) begin
					nxt_state = RS_SOFT_RST;
				end
			end
			RS_SOFT_RST: begin
				if (rst_cnt_ff == 16'h0000) begin
					nxt_state = RS_RELATCH;
				end
			end
			RS_RELATCH: begin
				nxt_state = RS_RUN;
			end
			default: begin
				nxt_state = RS_RUN;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_ff <= RS_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Reset length counter
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rst_cnt_ff <= 16'h0000;
		end else if (start_srst) begin
			rst_cnt_ff <= RST_LOAD;
		end else if (state_ff == RS_SOFT_RST && rst_cnt_ff != 16'h0000) begin
			rst_cnt_ff <= rst_cnt_ff - 16'h0001;
		end
	end

	// Plain control fields; soft reset returns them to defaults
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || start_srst || busy) begin
			loop_ff <= LOOP_RST;
			speed_ff <= SPEED_RST;
			an_en_ff <= ANEN_RST;
			iso_ff <= ISO_RST;
			col_test_ff <= COLT_RST;
		end else if (wr_bmc) begin
			loop_ff <= i_pwdata[LOOP_BIT];
			speed_ff <= i_pwdata[SPEED_BIT];
			an_en_ff <= i_pwdata[ANEN_BIT];
			iso_ff <= i_pwdata[ISO_BIT];
			col_test_ff <= i_pwdata[COLT_BIT];
		end
	end

	// Power-down bit; a low pin sets it and beats a clearing write
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pwdn_ff <= PWDN_RST;
		end else if (pin_pd_req) begin
			pwdn_ff <= 1'b1;
		end else if (start_srst || busy) begin
			pwdn_ff <= PWDN_RST;
		end else if (wr_bmc) begin
			pwdn_ff <= i_pwdata[PWDN_BIT];
		end
	end

	// Duplex: taken from the strap after either kind of reset
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			duplex_ff <= DUPLEX_RST;
			strap_wait_ff <= STRAP_WAIT;
		end else if (strap_wait_ff != 2'h0) begin
			strap_wait_ff <= strap_wait_ff - 2'h1;
			// Synchroniser holds a real sample only after two edges
			if (strap_wait_ff == 2'h1) begin
				duplex_ff <= strap_sync;
			end
		end else if (state_ff == RS_RELATCH) begin
			duplex_ff <= strap_sync;
		end else if (wr_bmc) begin
			duplex_ff <= i_pwdata[DUPLEX_BIT];
		end
	end

	// Restart flag stays up until the engine reports a start
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || start_srst || busy) begin
			an_rs_ff <= ANRS_RST;
		end else if (start_anrs) begin
			an_rs_ff <= 1'b1;
		end else if (i_an_started) begin
			an_rs_ff <= 1'b0;
		end
	end

	// One cycle restart request towards the engine
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			an_restart_ff <= 1'b0;
		end else begin
			an_restart_ff <= start_anrs;
		end
	end

	// Core controls
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			soft_rst_ff <= 1'b0;
			power_down_ff <= 1'b0;
		end else begin
			soft_rst_ff <= start_srst | (busy & (nxt_state != RS_RUN));
			power_down_ff <= pd_eff;
		end
	end

	// Resolved speed and duplex
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			speed_100_ff <= SPEED_RST;
			full_duplex_ff <= DUPLEX_RST;
		end else if (an_en_ff) begin
			speed_100_ff <= i_an_speed_100;
			full_duplex_ff <= i_an_full_duplex;
		end else begin
			speed_100_ff <= speed_ff;
			full_duplex_ff <= duplex_ff;
		end
	end

	// Transmit towards the line; loopback keeps frames off the wire
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			line_txd_ff <= '0;
			line_tx_en_ff <= 1'b0;
		end else if (mii_on && !loop_ff) begin
			line_txd_ff <= i_mii_txd;
			line_tx_en_ff <= i_mii_tx_en;
		end else begin
			line_txd_ff <= '0;
			line_tx_en_ff <= 1'b0;
		end
	end

	// Receive towards the MAC
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mii_rxd_ff <= '0;
			mii_rx_dv_ff <= 1'b0;
		end else if (!mii_on) begin
			mii_rxd_ff <= '0;
			mii_rx_dv_ff <= 1'b0;
		end else if (loop_ff) begin
			mii_rxd_ff <= i_mii_txd;
			mii_rx_dv_ff <= i_mii_tx_en;
		end else begin
			mii_rxd_ff <= i_line_rxd;
			mii_rx_dv_ff <= i_line_rx_dv;
		end
	end

	// Receive drivers released while isolated
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mii_rx_oe_n_ff <= 1'b0;
		end else begin
			mii_rx_oe_n_ff <= iso_ff;
		end
	end

	// Outputs straight from flops
	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_an_restart = an_restart_ff;
	assign o_an_enable = an_en_ff;
	assign o_soft_rst = soft_rst_ff;
	assign o_power_down = power_down_ff;
	assign o_speed_100 = speed_100_ff;
	assign o_full_duplex = full_duplex_ff;
	assign o_col_test = col_test_ff;
	assign o_mii_rxd = mii_rxd_ff;
	assign o_mii_rx_dv = mii_rx_dv_ff;
	assign o_mii_rx_oe_n = mii_rx_oe_n_ff;
	assign o_line_txd = line_txd_ff;
	assign o_line_tx_en = line_tx_en_ff;
endmodule // phy_basic_mode_control

// ===== testbench/phy_far_end_model.sv
`timescale 1ns/1ps
// Negotiation engine and line receive path beside the block
module phy_far_end_model (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_an_restart,
	output logic o_an_started,
	output logic o_an_speed_100,
	output logic o_an_full_duplex,
	output logic [3:0] o_line_rxd,
	output logic o_line_rx_dv
);
	logic [3:0] wait_ff;
	// Start is reported late, so the restart bit is seen set
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wait_ff <= 4'h0;
			o_an_started <= 1'b0;
		end else begin
			o_an_started <= (wait_ff == 4'h1);
			if (i_an_restart) begin
				wait_ff <= 4'h6;
			end else if (wait_ff != 4'h0) begin
				wait_ff <= wait_ff - 4'h1;
			end
		end
	end
	// Each negotiation flips the speed result
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_an_speed_100 <= 1'b1;
			o_an_full_duplex <= 1'b1;
		end else if (o_an_started) begin
			o_an_speed_100 <= !o_an_speed_100;
		end
	end
	// Receive lines change every cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_line_rxd <= 4'h0;
			o_line_rx_dv <= 1'b0;
		end else begin
			o_line_rxd <= o_line_rxd + 4'h1;
			o_line_rx_dv <= !o_line_rx_dv;
		end
	end
endmodule // phy_far_end_model

// ===== testbench/phy_bmc_assertions.sv
`timescale 1ns/1ps
module phy_bmc_assertions #(
	parameter int unsigned RST_CYCLES = 40,
	parameter int unsigned MII_W = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic i_shared_irq_powerdown_pin_n,
	input wire logic i_an_speed_100,
	input wire logic i_an_full_duplex,
	input wire logic o_an_restart,
	input wire logic o_an_enable,
	input wire logic o_soft_rst,
	input wire logic o_power_down,
	input wire logic o_speed_100,
	input wire logic o_full_duplex,
	input wire logic [MII_W-1:0] o_mii_rxd,
	input wire logic o_mii_rx_dv,
	input wire logic o_mii_rx_oe_n,
	input wire logic [MII_W-1:0] o_line_txd,
	input wire logic o_line_tx_en
);
	logic [15:0] busy_cnt_ff;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Cycles spent in soft reset
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !o_soft_rst) begin
			busy_cnt_ff <= 16'h0000;
		end else begin
			busy_cnt_ff <= busy_cnt_ff + 16'h0001;
		end
	end
	AST_SRST_START: assert property (i_psel && i_penable && o_pready && i_pwrite &&
		i_paddr == 12'h000 && i_pwdata[15] && !o_soft_rst |=> o_soft_rst)
		else $error("soft reset not started");
	AST_SRST_LEN: assert property ($fell(o_soft_rst) |->
		busy_cnt_ff >= RST_CYCLES + 1 && busy_cnt_ff <= RST_CYCLES + 2)
		else $error("soft reset length wrong");
	AST_PIN_PD: assert property (!i_shared_irq_powerdown_pin_n [*4] |->
		##[0:2] o_power_down)
		else $error("pin did not power down");
	AST_PD_LINE: assert property (o_power_down && $past(o_power_down) |->
		!o_line_tx_en && o_line_txd == '0)
		else $error("transmit active in power down");
	AST_SRST_LINE: assert property (o_soft_rst && $past(o_soft_rst) |-> !o_line_tx_en)
		else $error("transmit active in soft reset");
	AST_ISO_RX: assert property (o_mii_rx_oe_n && $past(o_mii_rx_oe_n) |->
		o_mii_rxd == '0 && !o_mii_rx_dv)
		else $error("receive lines active while isolated");
	AST_ISO_TX: assert property (o_mii_rx_oe_n && $past(o_mii_rx_oe_n) |-> !o_line_tx_en)
		else $error("transmit passed while isolated");
	AST_AN_PULSE: assert property (o_an_restart |-> o_an_enable ##1 !o_an_restart)
		else $error("bad restart pulse");
	AST_AN_MODE: assert property ($past(o_an_enable) |->
		o_speed_100 == $past(i_an_speed_100) && o_full_duplex == $past(i_an_full_duplex))
		else $error("mode not from negotiation");
	AST_APB_ACK: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no register answer");
endmodule // phy_bmc_assertions
bind phy_basic_mode_control phy_bmc_assertions #(.RST_CYCLES(RST_CYCLES), .MII_W(MII_W)) u_chk (.*);

// ===== testbench/phy_basic_mode_control_tb_top.sv
`timescale 1ns/1ps
module phy_basic_mode_control_tb_top;
	import phy_bmc_pkg::*;
	logic i_ref_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, o_prdata, rd, d, t;
	logic i_shared_irq_powerdown_pin_n = 1, i_strap_duplex = 1, i_mii_tx_en = 0;
	logic o_pready, o_pslverr, er, i_an_started, i_an_speed_100, i_an_full_duplex;
	logic o_an_restart, o_an_enable, o_soft_rst, o_power_down, o_speed_100;
	logic o_full_duplex, o_col_test, o_mii_rx_dv, o_mii_rx_oe_n, i_line_rx_dv, o_line_tx_en;
	logic [3:0] i_mii_txd = 0, o_mii_rxd, i_line_rxd, o_line_txd;
	logic [2:0] c;
	int err_total = 0, n_compared = 0;
	phy_basic_mode_control #(.RST_CYCLES(8), .MII_W(4)) dut (.*);
	phy_far_end_model u_far (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_an_restart(o_an_restart),
		.o_an_started(i_an_started), .o_an_speed_100(i_an_speed_100),
		.o_an_full_duplex(i_an_full_duplex), .o_line_rxd(i_line_rxd), .o_line_rx_dv(i_line_rx_dv));
	always #12.5 i_ref_clk = ~i_ref_clk;
	// MAC transmit traffic, random every cycle
	always @(posedge i_ref_clk) begin
		i_mii_txd <= 4'($urandom);
		i_mii_tx_en <= 1'($urandom);
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge i_ref_clk);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, v};
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		// Only the watchdog ends a wait that never sees the answer
		do begin
			@(posedge i_ref_clk);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		{i_psel, i_penable} <= 2'b00;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask
	// Resolved speed and duplex for a control setting
	function automatic logic [31:0] mode(input logic [2:0] m);
		return m[2] ? {30'h0, i_an_speed_100, i_an_full_duplex} : {30'h0, m[1], m[0]};
	endfunction
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		err_total++;
		stop_test();
	end
	initial begin
		void'($urandom(6305));
		repeat (3) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		apb(0, BMC_OFFS, 32'h0);
		chk(rd, 32'h0000_3100);
		apb(0, 12'h008, 32'h0);
		chk({rd[30:0], er}, 32'h0000_0001);
		// Every mode setting, with random filler in ignored bits and in the collision test bit
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			d = ($urandom & 32'hFFFF_00FF) | (32'(c[1]) << 13) | (32'(c[2]) << 12) | (32'(c[0]) << 8);
			apb(1, BMC_OFFS, d);
			repeat (3) @(posedge i_ref_clk);
			chk({30'h0, o_speed_100, o_full_duplex}, mode(c));
			chk(32'(o_col_test), 32'(d[7]));
			apb(0, BMC_OFFS, 32'h0);
			chk(rd, d & 32'h0000_3180);
		end
		apb(1, BMC_OFFS, 32'h0000_5000);
		repeat (2) @(posedge i_ref_clk);
		for (int i = 0; i < 8; i++) begin
			@(negedge i_ref_clk);
			t = {27'h0, i_mii_tx_en, i_mii_txd};
			@(posedge i_ref_clk);
			#1 chk({27'h0, o_mii_rx_dv, o_mii_rxd}, t);
		end
		apb(1, BMC_OFFS, 32'h0000_1200);
		apb(0, BMC_OFFS, 32'h0);
		chk(rd & 32'h0000_0200, 32'h0000_0200);
		repeat (15) @(posedge i_ref_clk);
		apb(0, BMC_OFFS, 32'h0);
		chk(rd & 32'h0000_0200, 32'h0);
		apb(1, BMC_OFFS, 32'h0000_0200);
		apb(0, BMC_OFFS, 32'h0);
		chk(rd & 32'h0000_1200, 32'h0);
		apb(1, BMC_OFFS, 32'h0000_0800);
		apb(0, BMC_OFFS, 32'h0);
		chk({rd[11], o_power_down}, 2'b11);
		apb(1, BMC_OFFS, 32'h0);
		i_shared_irq_powerdown_pin_n <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
		apb(0, BMC_OFFS, 32'h0);
		chk({rd[11], o_power_down}, 2'b11);
		i_shared_irq_powerdown_pin_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		apb(1, BMC_OFFS, 32'h0);
		apb(0, BMC_OFFS, 32'h0);
		chk({rd[11], o_power_down}, 2'b00);
		apb(1, BMC_OFFS, 32'h0000_0400);
		repeat (3) @(posedge i_ref_clk);
		apb(0, BMC_OFFS, 32'h0);
		chk({rd[10], o_mii_rx_oe_n}, 2'b11);
		// Status view: manual 10 Mb/s half duplex, isolated, nothing else
		apb(0, STAT_OFFS, 32'h0);
		chk(rd, 32'h0000_0008);
		i_strap_duplex <= 1'b0;
		apb(1, BMC_OFFS, 32'h0000_4400);
		apb(1, BMC_OFFS, 32'h0000_8000);
		apb(0, BMC_OFFS, 32'h0);
		chk({rd[15], o_soft_rst}, 2'b11);
		do begin
			apb(0, BMC_OFFS, 32'h0);
		end while (rd[15] !== 1'b0);
		chk(rd, 32'h0000_3000);
		stop_test();
	end
endmodule // phy_basic_mode_control_tb_top
